// ### piyx_cfg.svh
// Constants for the port-input and Y-increment execution block
`ifndef PIYX_CFG_SVH
`define PIYX_CFG_SVH
`define PIYX_OP_LOAD_ONE   10'h261
`define PIYX_OP_LOAD_TWO   10'h262
`define PIYX_OP_LOAD_THREE 10'h263
`define PIYX_OP_INC_Y      10'h013
`define PIYX_NIB_ZERO     4'h0
`define PIYX_NIB_ONE      4'h1
`define PIYX_HI2_ZERO     2'h0
`define PIYX_Y_RESET      4'h0
`define PIYX_A_RESET      4'h0
`endif

// ### piyx_exec.sv
// Execution of the port-input and Y-increment-with-skip instructions
// How it works
// - Port-one input instruction copies all four port-one levels into accumulator.
// - Port-two input loads accumulator bits 1:0 from port two, clears 3:2.
// - Port-three input loads accumulator bits 1:0 from port three, clears 3:2.
// - Y increment adds one; a zero result skips the next instruction.
`timescale 1ns/1ps
`default_nettype none
`include "piyx_cfg.svh"
module piyx_exec (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Instruction from fetch/decode, one per cycle while valid
    input  wire logic       instr_valid,
    input  wire logic [9:0] instr_code,
    // Port input pins
    input  wire logic [3:0] port_one_inputs,
    input  wire logic [1:0] port_two_inputs,
    input  wire logic [1:0] port_three_inputs,
    // Carry flag load from the rest of the core
    input  wire logic       carry_we,
    input  wire logic       carry_in,
    // Register file view
    output logic      [3:0] acc,
    output logic      [3:0] y_reg,
    output logic            carry_flag,
    // Status to fetch stage
    output logic            instr_done,
    output logic            instr_skipped,
    output logic            skip_next
);
    logic [3:0] one_lvl;
    logic [1:0] two_lvl;
    logic [1:0] three_lvl;

    piyx_pin_sync u_sync (
        .clk_sys           (clk_sys),
        .rst               (rst),
        .port_one_inputs   (port_one_inputs),
        .port_two_inputs   (port_two_inputs),
        .port_three_inputs (port_three_inputs),
        .one_lvl           (one_lvl),
        .two_lvl           (two_lvl),
        .three_lvl         (three_lvl)
    );

    piyx_pkg::piyx_core_s st_q;
    piyx_pkg::piyx_core_s st_d;
    piyx_pkg::piyx_op_e   op;
    logic                 exec_en;
    logic [3:0]           y_inc;

    always_comb begin
        unique case (instr_code)
            `PIYX_OP_LOAD_ONE:   op = piyx_pkg::PIYX_OP_PORT1;
            `PIYX_OP_LOAD_TWO:   op = piyx_pkg::PIYX_OP_PORT2;
            `PIYX_OP_LOAD_THREE: op = piyx_pkg::PIYX_OP_PORT3;
            `PIYX_OP_INC_Y:      op = piyx_pkg::PIYX_OP_INCY;
            default:             op = piyx_pkg::PIYX_OP_NONE;
        endcase
    end

    // A pending skip turns the next valid word into an idle cycle
    assign exec_en = instr_valid && !st_q.skip_pending;
    // Four-bit add keeps the natural wrap from fifteen to zero
    assign y_inc   = st_q.y + `PIYX_NIB_ONE;

    always_comb begin
        st_d = st_q;
        if (carry_we) begin
            st_d.carry = carry_in;
        end
        if (instr_valid) begin
            st_d.skip_pending = 1'b0;
        end
        if (exec_en) begin
            unique case (op)
                piyx_pkg::PIYX_OP_PORT1: st_d.acc = one_lvl;
                piyx_pkg::PIYX_OP_PORT2: st_d.acc = {`PIYX_HI2_ZERO, two_lvl};
                piyx_pkg::PIYX_OP_PORT3: st_d.acc = {`PIYX_HI2_ZERO, three_lvl};
                piyx_pkg::PIYX_OP_INCY: begin
                    st_d.y            = y_inc;
                    st_d.skip_pending = (y_inc == `PIYX_NIB_ZERO);
                end
                piyx_pkg::PIYX_OP_NONE: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '{acc: `PIYX_A_RESET, y: `PIYX_Y_RESET, carry: 1'b0, skip_pending: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign acc           = st_q.acc;
    assign y_reg         = st_q.y;
    assign carry_flag    = st_q.carry;
    assign skip_next     = st_q.skip_pending;
    assign instr_done    = exec_en && (op != piyx_pkg::PIYX_OP_NONE);
    assign instr_skipped = instr_valid && st_q.skip_pending;

    chk_port1_load: assert property (@(posedge clk_sys) disable iff (rst)
        exec_en && op == piyx_pkg::PIYX_OP_PORT1 |=> acc == $past(one_lvl))
        else $error("port one load wrong");
    chk_port2_load: assert property (@(posedge clk_sys) disable iff (rst)
        exec_en && op == piyx_pkg::PIYX_OP_PORT2 |=> acc == {2'h0, $past(two_lvl)})
        else $error("port two load wrong");
    chk_port3_load: assert property (@(posedge clk_sys) disable iff (rst)
        exec_en && op == piyx_pkg::PIYX_OP_PORT3
        |=> acc[3:2] == 2'h0 && acc[1:0] == $past(three_lvl))
        else $error("port three load wrong");
    chk_y_incr: assert property (@(posedge clk_sys) disable iff (rst)
        exec_en && op == piyx_pkg::PIYX_OP_INCY |=> y_reg == 4'($past(y_reg) + 4'h1))
        else $error("Y increment wrong");
    chk_skip_zero: assert property (@(posedge clk_sys) disable iff (rst)
        exec_en && op == piyx_pkg::PIYX_OP_INCY |=> skip_next == (y_reg == 4'h0))
        else $error("skip flag disagrees with Y");
    chk_y_wrap: assert property (@(posedge clk_sys) disable iff (rst)
        exec_en && op == piyx_pkg::PIYX_OP_INCY && y_reg == 4'hF |=> y_reg == 4'h0 && skip_next)
        else $error("Y did not wrap");
    chk_skip_idle: assert property (@(posedge clk_sys) disable iff (rst)
        instr_skipped |=> $stable(acc) && $stable(y_reg) && !skip_next)
        else $error("skipped cycle changed state");
    chk_carry_kept: assert property (@(posedge clk_sys) disable iff (rst)
        !carry_we |=> $stable(carry_flag))
        else $error("carry changed without load");
endmodule : piyx_exec
`default_nettype wire

// ### piyx_pin_model.sv
// Pin driver standing in for the external port pins
`timescale 1ns/1ps
`default_nettype none
module piyx_pin_model (
    // Clock
    input  wire logic       clk_sys,
    // Requested levels
    input  wire logic [3:0] one_req,
    input  wire logic [1:0] two_req,
    input  wire logic [1:0] three_req,
    // Pins
    output logic      [3:0] port_one_inputs,
    output logic      [1:0] port_two_inputs,
    output logic      [1:0] port_three_inputs
);
    // Pins are never left floating, so they simply hold the last request
    always @(posedge clk_sys) begin
        port_one_inputs <= one_req;
        port_two_inputs <= two_req;
        port_three_inputs <= three_req;
    end
endmodule : piyx_pin_model
`default_nettype wire

// ### piyx_pin_sync.sv
// Three-stage synchronisers with agreement filter for the port input pins
`timescale 1ns/1ps
`default_nettype none
`include "piyx_cfg.svh"
module piyx_pin_sync (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Raw pins
    input  wire logic [3:0] port_one_inputs,
    input  wire logic [1:0] port_two_inputs,
    input  wire logic [1:0] port_three_inputs,
    // Filtered levels
    output logic      [3:0] one_lvl,
    output logic      [1:0] two_lvl,
    output logic      [1:0] three_lvl
);
    piyx_pkg::piyx_sync_s sy_q;
    piyx_pkg::piyx_sync_s sy_d;

    // Stage one feeds only stage two; a level counts once stages two and three agree
    always_comb begin
        sy_d          = sy_q;
        sy_d.one_s1   = port_one_inputs;
        sy_d.one_s2   = sy_q.one_s1;
        sy_d.one_s3   = sy_q.one_s2;
        sy_d.one_v    = (sy_q.one_s2 & sy_q.one_s3)
                      | (sy_q.one_v & (sy_q.one_s2 | sy_q.one_s3));
        sy_d.two_s1   = port_two_inputs;
        sy_d.two_s2   = sy_q.two_s1;
        sy_d.two_s3   = sy_q.two_s2;
        sy_d.two_v    = (sy_q.two_s2 & sy_q.two_s3)
                      | (sy_q.two_v & (sy_q.two_s2 | sy_q.two_s3));
        sy_d.three_s1 = port_three_inputs;
        sy_d.three_s2 = sy_q.three_s1;
        sy_d.three_s3 = sy_q.three_s2;
        sy_d.three_v  = (sy_q.three_s2 & sy_q.three_s3)
                      | (sy_q.three_v & (sy_q.three_s2 | sy_q.three_s3));
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sy_q <= '0;
        end else begin
            sy_q <= sy_d;
        end
    end

    assign one_lvl   = sy_q.one_v;
    assign two_lvl   = sy_q.two_v;
    assign three_lvl = sy_q.three_v;
endmodule : piyx_pin_sync
`default_nettype wire

// ### piyx_pkg.sv
// Types for the port-input and Y-increment execution block
package piyx_pkg;
    typedef enum logic [2:0] {
        PIYX_OP_NONE,
        PIYX_OP_PORT1,
        PIYX_OP_PORT2,
        PIYX_OP_PORT3,
        PIYX_OP_INCY
    } piyx_op_e;

    typedef struct packed {
        logic [3:0] one_s1;
        logic [3:0] one_s2;
        logic [3:0] one_s3;
        logic [3:0] one_v;
        logic [1:0] two_s1;
        logic [1:0] two_s2;
        logic [1:0] two_s3;
        logic [1:0] two_v;
        logic [1:0] three_s1;
        logic [1:0] three_s2;
        logic [1:0] three_s3;
        logic [1:0] three_v;
    } piyx_sync_s;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] y;
        logic       carry;
        logic       skip_pending;
    } piyx_core_s;
endpackage : piyx_pkg

// ### tb.sv
// Self-checking bench for the port-input and Y-increment block
`timescale 1ns/1ps
`default_nettype none
`include "piyx_cfg.svh"
module tb;
    logic       clk_sys = 1'h0, rst = 1'h1, instr_valid = 1'h0, carry_we = 1'h0, carry_in = 1'h0;
    logic [9:0] instr_code = 10'h000;
    logic [3:0] one_req = 4'h0;
    logic [1:0] two_req = 2'h0, three_req = 2'h0, pp2, pp3;
    logic [3:0] pp1, acc, y_reg;
    logic [1:0] port_two_inputs, port_three_inputs;
    logic [3:0] port_one_inputs;
    logic       carry_flag, instr_done, instr_skipped, skip_next;
    logic [7:0] r = 8'h28;
    int         errors = 0, compares = 0, cycles = 0, m_acc = 0, m_y = 0, m_carry = 0, m_skip = 0;

    always #2.5 clk_sys = ~clk_sys;

    piyx_pin_model piyx_pin_model_i (.clk_sys(clk_sys), .one_req(one_req), .two_req(two_req),
        .three_req(three_req), .port_one_inputs(port_one_inputs),
        .port_two_inputs(port_two_inputs), .port_three_inputs(port_three_inputs));
    piyx_exec piyx_exec_i (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
        .instr_code(instr_code), .port_one_inputs(port_one_inputs),
        .port_two_inputs(port_two_inputs), .port_three_inputs(port_three_inputs),
        .carry_we(carry_we), .carry_in(carry_in), .acc(acc), .y_reg(y_reg),
        .carry_flag(carry_flag), .instr_done(instr_done), .instr_skipped(instr_skipped),
        .skip_next(skip_next));

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic regs();
        chk(acc, m_acc[3:0]);
        chk(y_reg, m_y[3:0]);
        chk({3'h0, carry_flag}, m_carry[3:0]);
        chk({3'h0, skip_next}, m_skip[3:0]);
    endtask : regs

    task automatic run(input logic [9:0] c);
        @(posedge clk_sys);
        instr_valid <= 1'h1;
        instr_code <= c;
        @(negedge clk_sys);
        regs();
        chk({3'h0, instr_skipped}, m_skip[3:0]);
        chk({3'h0, instr_done}, {3'h0, !m_skip && (c == `PIYX_OP_LOAD_ONE
            || c == `PIYX_OP_LOAD_TWO || c == `PIYX_OP_LOAD_THREE || c == `PIYX_OP_INC_Y)});
        if (m_skip != 0) m_skip = 0;
        else if (c == `PIYX_OP_LOAD_ONE) m_acc = pp1;
        else if (c == `PIYX_OP_LOAD_TWO) m_acc = pp2;
        else if (c == `PIYX_OP_LOAD_THREE) m_acc = pp3;
        else if (c == `PIYX_OP_INC_Y) begin
            m_y = (m_y + 1) % 16;
            m_skip = (m_y == 0);
        end
    endtask : run

    // Pins need several idle cycles to pass the synchroniser before a load
    task automatic idle(input int n);
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        carry_we <= 1'h1;
        carry_in <= r[0];
        {one_req, two_req, three_req} <= r;
        @(negedge clk_sys);
        regs();
        m_carry = r[0];
        {pp1, pp2, pp3} = r;
        @(posedge clk_sys);
        carry_we <= 1'h0;
        repeat (n) @(posedge clk_sys);
    endtask : idle

    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 2000) begin
            errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        for (int i = 0; i < 12; i++) begin
            r = lfsr(r);
            idle(7);
            run(`PIYX_OP_LOAD_ONE);
            run(`PIYX_OP_LOAD_TWO);
            run(`PIYX_OP_LOAD_THREE);
            run(r[1] ? `PIYX_OP_INC_Y : {2'h0, r});
            $display("port load test %0d done", i);
        end
        repeat (18) run(`PIYX_OP_INC_Y);
        while (m_y != 15) run(`PIYX_OP_INC_Y);
        run(`PIYX_OP_INC_Y);
        idle(2);
        run(`PIYX_OP_LOAD_ONE);
        idle(1);
        $display("increment and skip test done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
